// File: rtl/srwd_supervisor.sv
// Supply supervisor: reset generator, windowed watchdog, power-good pins.
//
// Operation
// RULE_01: Reset pulled low while sense is low or pump is out of regulation.
// RULE_02: After both conditions are good, hold reset one timeout then release.
// RULE_03: Qualifying conditions are glitch filtered before they take effect.
// RULE_04: Undervoltage lockout holds reset low and blocks the timeout start.
// RULE_05: Reset timeout chosen by strap: open, tied to pump, or capacitor.
// RULE_06: Watchdog runs only while sense is above threshold.
// RULE_07: Kicks spaced inside the window keep reset released.
// RULE_08: Early kick or missing kick asserts reset one timeout, then restarts.
// RULE_09: Watchdog counter stays cleared while reset is asserted; code clears it one cycle after a filter fall in run pulls reset.
// RULE_10: Upper window limit is one watchdog clock before expiry.
// RULE_11: Internal mode expires at 8193 ticks, lower limit one thirty-second.
// RULE_12: External mode expires at 129 ticks, upper limit at tick 128.
// RULE_13: External mode lower limit is five ticks in.
// RULE_14: Watchdog strap: grounded disables, bias gives internal, else cap.
// RULE_15: Both power-good pins low when both enables low or in lockout.
// RULE_16: Otherwise each power-good pin low while its rail is out of window.
// RULE_17: Open-drain pins are pull-low enables; comparators come synchronised.
`timescale 1ns/1ns
`include "srwd_consts.svh"
module srwd_supervisor
    import srwd_pkg::*;
#(
    parameter int unsigned P_RST_OPEN_CYC = `SRWD_RST_OPEN_CYC,
    parameter int unsigned P_RST_PUMP_CYC = `SRWD_RST_PUMP_CYC,
    parameter int unsigned P_WD_INT_TICK_CYC = `SRWD_WD_INT_TICK_CYC
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_reset_sense_in,
    input wire logic i_pump_in_regulation,
    input wire logic i_uvlo,
    input wire logic i_watchdog_kick_in,
    input wire logic i_low_rail_enable,
    input wire logic i_high_rail_enable,
    input wire logic i_low_rail_over,
    input wire logic i_low_rail_under,
    input wire logic i_high_rail_over,
    input wire logic i_high_rail_under,
    input wire logic [1:0] i_reset_timing_strap,
    input wire logic [1:0] i_watchdog_timing_strap,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    output logic o_irq,
    output logic o_reset_out,
    output logic o_reset_oe,
    output logic o_good_low_rail_out,
    output logic o_good_low_rail_oe,
    output logic o_good_high_rail_out,
    output logic o_good_high_rail_oe
);

    srwd_regs_t s;
    srwd_regs_t next_s;

    logic uvlo;
    logic raw_ok;
    logic kick_fall;
    logic wd_on;
    logic wd_ext;
    logic [13:0] wd_upper;
    logic [13:0] wd_lower;
    logic [31:0] tick_period;
    logic [31:0] tmo_limit;
    logic tick;
    logic en_any;
    logic [`SRWD_EV_W-1:0] ev;
    logic [`SRWD_EV_W-1:0] clr;

    // Decoded views of the registered, synchronised inputs.
    assign uvlo = s.sync2[`SRWD_IN_UVLO];
    assign raw_ok = s.sync2[`SRWD_IN_SENSE] & s.sync2[`SRWD_IN_PUMP];
    assign kick_fall = s.kick_prev & ~s.sync2[`SRWD_IN_KICK];
    assign en_any = s.sync2[`SRWD_IN_EN_LOW] | s.sync2[`SRWD_IN_EN_HIGH];
    assign wd_ext = (s.wt_mode != `SRWD_WT_BIAS);
    // RULE_14: watchdog mode select
    assign wd_on = (s.wt_mode != `SRWD_WT_GND) && (s.strap_cnt == 2'h3);
    // RULE_11: internal window limits
    // RULE_12: external window limits
    // RULE_13: external lower limit
    assign wd_upper = wd_ext ? 14'(`SRWD_WD_EXT_UPPER)
                             : 14'(`SRWD_WD_INT_UPPER);
    assign wd_lower = wd_ext ? 14'(`SRWD_WD_EXT_LOWER)
                             : 14'(`SRWD_WD_INT_LOWER);
    // A zero capacitor period would stall the watchdog clock, so it is one.
    assign tick_period = wd_ext ? ((s.wt_cap == 32'h0) ? 32'h1 : s.wt_cap)
                                : 32'(P_WD_INT_TICK_CYC);
    assign tick = (s.tick_cnt >= tick_period - 32'h1);

    // RULE_05: reset timeout select
    always_comb begin
        unique case (s.rt_mode)
            `SRWD_RT_OPEN: tmo_limit = 32'(P_RST_OPEN_CYC);
            `SRWD_RT_PUMP: tmo_limit = 32'(P_RST_PUMP_CYC);
            default: tmo_limit = (s.rt_cap == 32'h0) ? 32'h1 : s.rt_cap;
        endcase
    end

    assign clr = (i_wr && i_addr == `SRWD_REG_IRQ_STAT)
               ? i_wdata[`SRWD_EV_W-1:0] : '0;

    always_comb begin
        next_s = s;
        ev = '0;
        if (i_ce) begin
            // RULE_17: inputs pass two flip-flops
            next_s.sync1 = {i_watchdog_timing_strap, i_reset_timing_strap,
                            i_high_rail_under, i_high_rail_over,
                            i_low_rail_under, i_low_rail_over,
                            i_high_rail_enable, i_low_rail_enable,
                            i_watchdog_kick_in, i_uvlo,
                            i_pump_in_regulation, i_reset_sense_in};
            next_s.sync2 = s.sync1;
            next_s.kick_prev = s.sync2[`SRWD_IN_KICK];

            // Straps are taken once the synchroniser holds real pin levels.
            if (s.strap_cnt != 2'h3) begin
                next_s.strap_cnt = s.strap_cnt + 2'h1;
                next_s.rt_mode = s.sync2[`SRWD_IN_RT+:2];
                next_s.wt_mode = s.sync2[`SRWD_IN_WT+:2];
            end

            // RULE_03: qualifying glitch filter
            if (raw_ok == s.filt_ok) begin
                next_s.filt_cnt = 8'h0;
            end else if (s.filt_cnt == 8'(`SRWD_FILT_CYC - 1)) begin
                next_s.filt_ok = raw_ok;
                next_s.filt_cnt = 8'h0;
            end else begin
                next_s.filt_cnt = s.filt_cnt + 8'h1;
            end

            unique case (s.state)
                SRWD_HOLD: begin
                    // RULE_04: timeout waits for lockout
                    if (!uvlo && s.filt_ok && s.strap_cnt == 2'h3) begin
                        next_s.state = SRWD_TIMEOUT;
                        next_s.tmo_cnt = 32'h0;
                    end
                end
                SRWD_TIMEOUT: begin
                    if (uvlo || !s.filt_ok) begin
                        next_s.state = SRWD_HOLD;
                    // RULE_02: release after timeout
                    end else if (s.tmo_cnt >= tmo_limit - 32'h1) begin
                        next_s.state = SRWD_RUN;
                        next_s.tick_cnt = 32'h0;
                    end else begin
                        next_s.tmo_cnt = s.tmo_cnt + 32'h1;
                    end
                end
                SRWD_RUN: begin
                    // RULE_01: supply fault pulls reset
                    if (uvlo || !s.filt_ok) begin
                        next_s.state = SRWD_HOLD;
                        ev[`SRWD_EV_SUPPLY] = 1'b1;
                    // RULE_06: watchdog only while sense good
                    end else if (wd_on) begin
                        next_s.tick_cnt = tick ? 32'h0 : s.tick_cnt + 32'h1;
                        if (kick_fall && s.wd_cnt < wd_lower) begin
                            // RULE_08: early kick resets
                            next_s.state = SRWD_TIMEOUT;
                            next_s.tmo_cnt = 32'h0;
                            ev[`SRWD_EV_EARLY] = 1'b1;
                        end else if (kick_fall) begin
                            // RULE_07: valid kick restarts window
                            next_s.wd_cnt = 14'h0;
                            next_s.tick_cnt = 32'h0;
                        end else if (s.wd_cnt == wd_upper) begin
                            // RULE_10: upper limit expiry
                            next_s.state = SRWD_TIMEOUT;
                            next_s.tmo_cnt = 32'h0;
                            ev[`SRWD_EV_LATE] = 1'b1;
                        end else if (tick) begin
                            next_s.wd_cnt = s.wd_cnt + 14'h1;
                        end
                    end
                end
            endcase

            // RULE_09: counter cleared outside run
            // RULE_14: cleared when disabled
            if (next_s.state != SRWD_RUN || !wd_on) begin
                next_s.wd_cnt = 14'h0;
            end
            // A failing filter pulls reset in the same edge as it falls.
            next_s.rst_pull = (next_s.state != SRWD_RUN) || !next_s.filt_ok;

            // RULE_15: both pins low when off
            // RULE_16: per-rail window check
            if (uvlo || !en_any) begin
                next_s.pg_low_pull = 1'b1;
                next_s.pg_high_pull = 1'b1;
            end else begin
                next_s.pg_low_pull = s.sync2[`SRWD_IN_OV_LOW]
                                   | s.sync2[`SRWD_IN_UV_LOW];
                next_s.pg_high_pull = s.sync2[`SRWD_IN_OV_HIGH]
                                    | s.sync2[`SRWD_IN_UV_HIGH];
            end
            ev[`SRWD_EV_PGOOD] = (next_s.pg_low_pull & ~s.pg_low_pull)
                               | (next_s.pg_high_pull & ~s.pg_high_pull);

            // Register bus; a new event wins over its own clear.
            next_s.irq_stat = (s.irq_stat & ~clr) | ev;
            if (i_wr) begin
                unique case (i_addr)
                    `SRWD_REG_RT_CAP: next_s.rt_cap = i_wdata;
                    `SRWD_REG_WT_CAP: next_s.wt_cap = i_wdata;
                    `SRWD_REG_IRQ_MASK:
                        next_s.irq_mask = i_wdata[`SRWD_EV_W-1:0];
                    default: ;
                endcase
            end
            next_s.rdata = 32'h0;
            if (i_rd) begin
                unique case (i_addr)
                    `SRWD_REG_RT_CAP: next_s.rdata = s.rt_cap;
                    `SRWD_REG_WT_CAP: next_s.rdata = s.wt_cap;
                    `SRWD_REG_STATUS: next_s.rdata = {2'h0, s.wd_cnt,
                        4'h0, s.wt_mode, s.rt_mode, 3'h0, uvlo, s.filt_ok,
                        s.pg_high_pull, s.pg_low_pull, s.rst_pull};
                    `SRWD_REG_IRQ_STAT:
                        next_s.rdata = 32'(s.irq_stat);
                    `SRWD_REG_IRQ_MASK:
                        next_s.rdata = 32'(s.irq_mask);
                    default: next_s.rdata = 32'h0;
                endcase
            end
            next_s.irq = |(next_s.irq_stat & next_s.irq_mask);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            s <= '0;
            s.state <= SRWD_HOLD;
            s.rst_pull <= 1'b1;
            s.pg_low_pull <= 1'b1;
            s.pg_high_pull <= 1'b1;
            s.rt_cap <= `SRWD_RT_CAP_RST;
            s.wt_cap <= `SRWD_WT_CAP_RST;
            s.irq_mask <= `SRWD_IRQ_MASK_RST;
        end else begin
            s <= next_s;
        end
    end

    // RULE_17: pull-low enables only
    assign o_reset_out = 1'b0;
    assign o_reset_oe = s.rst_pull;
    assign o_good_low_rail_out = 1'b0;
    assign o_good_low_rail_oe = s.pg_low_pull;
    assign o_good_high_rail_out = 1'b0;
    assign o_good_high_rail_oe = s.pg_high_pull;
    assign o_irq = s.irq;
    assign o_rdata = s.rdata;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    uvlo_holds_reset_a: assert property ( // RULE_04
        (i_ce && uvlo) |=> (s.rst_pull && s.state == SRWD_HOLD))
        else $error("Reset not held during lockout.");
    fault_pulls_reset_a: assert property ( // RULE_01
        (i_ce && s.state == SRWD_RUN && !s.filt_ok) |=> o_reset_oe)
        else $error("Reset not pulled on supply fault.");
    release_means_run_a: assert property ( // RULE_02
        !o_reset_oe |-> (s.state == SRWD_RUN && s.filt_ok))
        else $error("Reset released outside run.");
    timeout_full_a: assert property ( // RULE_02
        (s.state == SRWD_RUN && $past(s.state) == SRWD_TIMEOUT)
        |-> $past(s.tmo_cnt) >= tmo_limit - 32'h1)
        else $error("Reset released before timeout ended.");
    filter_delay_a: assert property ( // RULE_03
        $changed(s.filt_ok) |-> $past(s.filt_cnt) == 8'(`SRWD_FILT_CYC - 1))
        else $error("Filter changed without full stable time.");
    wd_cleared_a: assert property ( // RULE_09
        (s.state != SRWD_RUN || !wd_on) |-> s.wd_cnt == 14'h0)
        else $error("Watchdog counter running in reset.");
    early_kick_a: assert property ( // RULE_08
        (i_ce && s.state == SRWD_RUN && wd_on && kick_fall && s.filt_ok
            && !uvlo && s.wd_cnt < wd_lower)
            |=> (o_reset_oe && s.tmo_cnt == 32'h0))
        else $error("Early kick did not reset.");
    late_kick_a: assert property ( // RULE_10
        (i_ce && s.state == SRWD_RUN && wd_on && !kick_fall
            && s.wd_cnt == wd_upper) |=> o_reset_oe)
        else $error("Missing kick did not reset.");
    window_bound_a: assert property ( // RULE_12
        s.state == SRWD_RUN |-> s.wd_cnt <= wd_upper)
        else $error("Watchdog count past upper limit.");
    good_kick_a: assert property ( // RULE_07
        (i_ce && s.state == SRWD_RUN && wd_on && kick_fall && s.filt_ok
            && !uvlo && s.wd_cnt >= wd_lower) |=> (!o_reset_oe
            && s.wd_cnt == 14'h0))
        else $error("Valid kick did not restart window.");
    pg_off_a: assert property ( // RULE_15
        (i_ce && (uvlo || !en_any)) |=> (o_good_low_rail_oe
            && o_good_high_rail_oe))
        else $error("Power-good not low while off.");
    pg_window_a: assert property ( // RULE_16
        (i_ce && !uvlo && en_any && !s.sync2[`SRWD_IN_OV_LOW]
            && !s.sync2[`SRWD_IN_UV_LOW]) |=> !o_good_low_rail_oe)
        else $error("Low rail good not released.");

    release_c: cover property (
        s.state == SRWD_TIMEOUT ##1 s.state == SRWD_RUN);
    early_c: cover property (s.irq_stat[`SRWD_EV_EARLY]);
    late_c: cover property (s.irq_stat[`SRWD_EV_LATE]);
    kick_ok_c: cover property (
        s.state == SRWD_RUN && kick_fall && s.wd_cnt >= wd_lower);

endmodule

// File: rtl/srwd_consts.svh
// Constants of the supply supervisor and windowed watchdog.
`ifndef SRWD_CONSTS_SVH
`define SRWD_CONSTS_SVH

// Clock rate and printed times.
`define SRWD_CLK_MHZ 125
`define SRWD_RST_OPEN_US 750
`define SRWD_RST_PUMP_MS 200
`define SRWD_WD_INT_MS 1600
`define SRWD_FILT_NS 1000

// Derived cycle counts.
`define SRWD_RST_OPEN_CYC (`SRWD_RST_OPEN_US * `SRWD_CLK_MHZ)
`define SRWD_RST_PUMP_CYC (`SRWD_RST_PUMP_MS * 1000 * `SRWD_CLK_MHZ)
`define SRWD_FILT_CYC ((`SRWD_FILT_NS * `SRWD_CLK_MHZ + 999) / 1000)

// Watchdog clock counts.
`define SRWD_WD_INT_EXPIRY 8193
`define SRWD_WD_EXT_EXPIRY 129
`define SRWD_WD_INT_DIV 32
`define SRWD_WD_EXT_LOWER 5
`define SRWD_WD_INT_UPPER (`SRWD_WD_INT_EXPIRY - 1)
`define SRWD_WD_EXT_UPPER (`SRWD_WD_EXT_EXPIRY - 1)
`define SRWD_WD_INT_LOWER (`SRWD_WD_INT_EXPIRY / `SRWD_WD_INT_DIV)
`define SRWD_WD_INT_TICK_CYC \
    (`SRWD_WD_INT_MS * 1000 * `SRWD_CLK_MHZ / `SRWD_WD_INT_EXPIRY)

// Strap codes.
`define SRWD_RT_OPEN 2'h0
`define SRWD_RT_PUMP 2'h1
`define SRWD_WT_GND 2'h0
`define SRWD_WT_BIAS 2'h1

// Synchroniser bit positions.
`define SRWD_IN_SENSE 0
`define SRWD_IN_PUMP 1
`define SRWD_IN_UVLO 2
`define SRWD_IN_KICK 3
`define SRWD_IN_EN_LOW 4
`define SRWD_IN_EN_HIGH 5
`define SRWD_IN_OV_LOW 6
`define SRWD_IN_UV_LOW 7
`define SRWD_IN_OV_HIGH 8
`define SRWD_IN_UV_HIGH 9
`define SRWD_IN_RT 10
`define SRWD_IN_WT 12
`define SRWD_IN_W 14

// Register offsets and reset values.
`define SRWD_REG_RT_CAP 8'h00
`define SRWD_REG_WT_CAP 8'h04
`define SRWD_REG_STATUS 8'h08
`define SRWD_REG_IRQ_STAT 8'h0c
`define SRWD_REG_IRQ_MASK 8'h10
`define SRWD_RT_CAP_RST 32'h0040_0000
`define SRWD_WT_CAP_RST 32'h0000_1000
`define SRWD_IRQ_MASK_RST 4'h0

// Interrupt bit positions.
`define SRWD_EV_SUPPLY 0
`define SRWD_EV_EARLY 1
`define SRWD_EV_LATE 2
`define SRWD_EV_PGOOD 3
`define SRWD_EV_W 4

`endif

// File: rtl/srwd_pkg.sv
// Types of the supply supervisor and windowed watchdog.
`include "srwd_consts.svh"
package srwd_pkg;

    typedef enum logic [1:0] {
        SRWD_HOLD,
        SRWD_TIMEOUT,
        SRWD_RUN
    } srwd_state_t;

    typedef struct packed {
        logic [`SRWD_IN_W-1:0] sync1;
        logic [`SRWD_IN_W-1:0] sync2;
        logic kick_prev;
        logic filt_ok;
        logic [7:0] filt_cnt;
        logic [1:0] strap_cnt;
        logic [1:0] rt_mode;
        logic [1:0] wt_mode;
        srwd_state_t state;
        logic [31:0] tmo_cnt;
        logic [31:0] tick_cnt;
        logic [13:0] wd_cnt;
        logic rst_pull;
        logic pg_low_pull;
        logic pg_high_pull;
        logic [31:0] rt_cap;
        logic [31:0] wt_cap;
        logic [`SRWD_EV_W-1:0] irq_stat;
        logic [`SRWD_EV_W-1:0] irq_mask;
        logic irq;
        logic [31:0] rdata;
    } srwd_regs_t;

endpackage

// File: test/srwd_host_model.sv
// Host model that kicks the watchdog with falling edges a set period apart.
`timescale 1ns/1ns
module srwd_host_model (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_go,
    input wire logic [15:0] i_period,
    output logic o_kick
);
    logic [15:0] cnt;
    logic [15:0] next_cnt;
    assign next_cnt = (cnt + 16'h0001 >= i_period) ? 16'h0000 : cnt + 16'h0001;
    always_ff @(posedge i_clk) begin
        if (i_rst || !i_go) begin
            cnt <= 16'h0000;
            o_kick <= 1'b1;
        end else begin
            cnt <= next_cnt;
            o_kick <= (next_cnt < (i_period >> 1));
        end
    end
endmodule

// File: test/srwd_supervisor_tb_top.sv
// Testbench of the supply supervisor and its windowed watchdog.
`timescale 1ns/1ns
`include "srwd_consts.svh"
module srwd_supervisor_tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic sense = 1'b1, pump = 1'b1, uvlo = 1'b1;
    logic en_l = 1'b1, en_h = 1'b1, ovl = 1'b0, uvl = 1'b0;
    logic ovh = 1'b0, uvh = 1'b0, wr = 1'b0, rd = 1'b0, go = 1'b0;
    logic [1:0] rts = 2'h0, wts = 2'h0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000, rdat, rv;
    logic [15:0] period = 16'h003c;
    logic kick, irq, rst_oe, rst_out, pgl_oe, pgh_oe, pgl_out, pgh_out;
    int mismatches = 0, n_compared = 0, n, seed;
    always #4 clk = ~clk;
    srwd_supervisor #(.P_RST_OPEN_CYC(20), .P_RST_PUMP_CYC(40),
        .P_WD_INT_TICK_CYC(2)) dut (.i_clk(clk), .i_rst(rst), .i_ce(1'b1),
        .i_reset_sense_in(sense), .i_pump_in_regulation(pump),
        .i_uvlo(uvlo), .i_watchdog_kick_in(kick), .i_low_rail_enable(en_l),
        .i_high_rail_enable(en_h), .i_low_rail_over(ovl),
        .i_low_rail_under(uvl), .i_high_rail_over(ovh),
        .i_high_rail_under(uvh), .i_reset_timing_strap(rts),
        .i_watchdog_timing_strap(wts), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdat), .o_irq(irq),
        .o_reset_out(rst_out), .o_reset_oe(rst_oe),
        .o_good_low_rail_out(pgl_out), .o_good_low_rail_oe(pgl_oe),
        .o_good_high_rail_out(pgh_out), .o_good_high_rail_oe(pgh_oe));
    srwd_host_model host (.i_clk(clk), .i_rst(rst), .i_go(go),
        .i_period(period), .o_kick(kick));
    task automatic final_report();
        if (mismatches == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // A count out of range is reported with the lower bound as expectation.
    task automatic in_range(string name, int v, int lo, int hi);
        check(name, 32'((v < lo || v > hi) ? v : lo), 32'(lo));
    endtask
    // A power-good pin pulls low when off, locked out or out of window.
    function automatic logic pg_exp(logic u, logic a, logic b, logic f);
        return u | ~(a | b) | f;
    endfunction
    task automatic wait_oe(logic val, int bound, output int cnt);
        cnt = 0;
        while (rst_oe !== val) begin
            @(posedge clk);
            #1;
            cnt++;
            if (cnt > bound) begin
                mismatches++;
                $display("Error reset_wait expected %b seen %b", val, rst_oe);
                final_report();
            end
        end
    endtask
    task automatic hold_oe(logic val, int cycles);
        logic bad;
        bad = 1'b0;
        repeat (cycles) begin
            @(posedge clk);
            #1;
            bad |= (rst_oe !== val);
        end
        check("reset_held", {31'h0, bad}, 32'h0);
    endtask
    task automatic reg_wr(logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic reg_rd(logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdat;
    endtask
    // Straps are captured once, so each timing mode needs a fresh reset.
    task automatic restart(logic [1:0] r, logic [1:0] w, int tmo);
        @(posedge clk);
        rst <= 1'b1;
        uvlo <= 1'b1;
        go <= 1'b0;
        rts <= r;
        wts <= w;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        hold_oe(1'b1, 150);
        reg_wr(`SRWD_REG_RT_CAP, 32'h0000_003c);
        reg_wr(`SRWD_REG_WT_CAP, 32'h0000_0004);
        @(posedge clk);
        uvlo <= 1'b0;
        wait_oe(1'b0, 200, n);
        in_range("release_time", n, tmo + 1, tmo + 8);
    endtask
    initial begin
        seed = $urandom(32'h32693486);
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        check("reset_pull", {31'h0, rst_oe}, 32'h1);
        check("pins_low", {29'h0, rst_out, pgl_out, pgh_out}, 32'h0);
        reg_rd(`SRWD_REG_RT_CAP, rv);
        check("rt_cap", rv, `SRWD_RT_CAP_RST);
        reg_rd(`SRWD_REG_WT_CAP, rv);
        check("wt_cap", rv, `SRWD_WT_CAP_RST);
        reg_rd(`SRWD_REG_IRQ_MASK, rv);
        check("irq_mask", rv, 32'h0000_0000);
        reg_rd(8'h14, rv);
        check("unmapped", rv, 32'h0000_0000);
        restart(2'h1, 2'h0, 40);
        restart(2'h2, 2'h0, 60);
        restart(2'h0, 2'h0, 20);
        hold_oe(1'b0, 17000);
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            sense <= (k != 0);
            pump <= (k == 0);
            repeat (50) @(posedge clk);
            sense <= 1'b1;
            pump <= 1'b1;
            hold_oe(1'b0, 200);
            @(posedge clk);
            sense <= (k != 0);
            pump <= (k == 0);
            wait_oe(1'b1, 300, n);
            in_range("fault_time", n, 125, 135);
            @(posedge clk);
            sense <= 1'b1;
            pump <= 1'b1;
            wait_oe(1'b0, 400, n);
            in_range("recover_time", n, 145, 160);
        end
        restart(2'h0, 2'h2, 20);
        reg_rd(`SRWD_REG_STATUS, rv);
        check("status", rv & 32'h0000_ffff, 32'h0000_0808);
        reg_wr(`SRWD_REG_IRQ_MASK, 32'h0000_0002);
        @(posedge clk);
        period <= 16'h0030 + 16'($urandom % 400);
        go <= 1'b1;
        hold_oe(1'b0, 3000);
        @(posedge clk);
        period <= 16'h000c;
        wait_oe(1'b1, 1000, n);
        @(posedge clk);
        go <= 1'b0;
        wait_oe(1'b0, 100, n);
        in_range("wd_restart", n, 16, 22);
        check("irq_on", {31'h0, irq}, 32'h1);
        reg_rd(`SRWD_REG_IRQ_STAT, rv);
        check("early_flag", rv & 32'h2, 32'h2);
        reg_wr(`SRWD_REG_IRQ_STAT, 32'h0000_0002);
        reg_rd(`SRWD_REG_IRQ_STAT, rv);
        check("early_clr", rv & 32'h2, 32'h0);
        check("irq_off", {31'h0, irq}, 32'h0);
        @(posedge clk);
        period <= 16'h003c;
        go <= 1'b1;
        hold_oe(1'b0, 600);
        // Wait for a fresh falling edge, so expiry is timed from it.
        for (int i = 0; i < 100 && kick !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        for (int i = 0; i < 100 && kick !== 1'b0; i++) begin
            @(posedge clk);
            #1;
        end
        check("kick_fall", {31'h0, kick}, 32'h0);
        if (kick !== 1'b0)
            final_report();
        @(posedge clk);
        go <= 1'b0;
        wait_oe(1'b1, 700, n);
        in_range("ext_expiry", n, 508, 518);
        reg_rd(`SRWD_REG_IRQ_STAT, rv);
        check("late_flag", rv & 32'h4, 32'h4);
        check("irq_masked", {31'h0, irq}, 32'h0);
        restart(2'h0, 2'h1, 20);
        wait_oe(1'b1, 16500, n);
        in_range("int_expiry", n, 16380, 16392);
        wait_oe(1'b0, 100, n);
        @(posedge clk);
        period <= 16'h04b0;
        go <= 1'b1;
        hold_oe(1'b0, 20000);
        @(posedge clk);
        period <= 16'h0190;
        wait_oe(1'b1, 2000, n);
        @(posedge clk);
        go <= 1'b0;
        for (int i = 0; i < 40; i++) begin
            @(posedge clk);
            {uvlo, en_l, en_h, ovl, uvl, ovh, uvh} <= 7'($urandom);
            repeat (4) @(posedge clk);
            #1;
            check("pg_low", {31'h0, pgl_oe},
                {31'h0, pg_exp(uvlo, en_l, en_h, ovl | uvl)});
            check("pg_high", {31'h0, pgh_oe},
                {31'h0, pg_exp(uvlo, en_l, en_h, ovh | uvh)});
            if (uvlo)
                check("lockout", {31'h0, rst_oe}, 32'h1);
        end
        final_report();
    end
endmodule
